/* File: gpio_consts.svh */
// Behaviour
// - after reset all pins are inputs with output drivers off.
// - input pins flag events on high, low, rising, falling or both edges.
// - per-pin open-drain option, push-pull after reset.
// - per-pin weak pull-up or pull-down, both off after reset.
// - per-pin switch to peripheral function, port control after reset.
// - up to eight pins; mask bit n is pin n, pin 0 at bit 0.
// - data register address bits form a pin mask for one access.
// - masked data read returns selected pins only, others read zero.
// - masked data write updates selected pins together, others unchanged.
// - per-pin direction: software input, software output or peripheral; readable.
// - per-pin ADC trigger enable; cleared enable gives no trigger.
// - ADC-trigger pin still raises its own event.
// - only enabled event sources reach the interrupt output.
// - raw and masked status readable, one bit per pin plus DMA bit.
// - per-pin DMA trigger enable; pin still raises its events.
`ifndef GPIO_CONSTS_SVH
`define GPIO_CONSTS_SVH

// ==========================================================
// register byte offsets
`define GPIO_DATA_LAST   12'h3FC
`define GPIO_DIR_OFS     12'h400
`define GPIO_ODEN_OFS    12'h404
`define GPIO_PUP_OFS     12'h408
`define GPIO_PDN_OFS     12'h40C
`define GPIO_TYPE_OFS    12'h410
`define GPIO_IEN_OFS     12'h414
`define GPIO_RAW_OFS     12'h418
`define GPIO_MSK_OFS     12'h41C
`define GPIO_ICLR_OFS    12'h420
`define GPIO_ADCEN_OFS   12'h424
`define GPIO_DMAEN_OFS   12'h428

// ==========================================================
// field positions and reset values
`define GPIO_MASK_LSB    2
`define GPIO_DMA_BIT     8
`define GPIO_DIR_RST     16'h0000
`define GPIO_TYPE_RST    24'h000000
`define GPIO_BITS_RST    8'h00
`define GPIO_IEN_RST     9'h000

`endif

/* File: gpio_pkg.sv */
package gpio_pkg;
  typedef enum logic [1:0] {
    dir_sw_input,
    dir_sw_output,
    dir_peripheral_controlled
  } dir_mode_e;

  typedef enum logic [2:0] {
    trig_off,
    trig_low_level,
    trig_high_level,
    trig_falling,
    trig_rising,
    trig_both_edges
  } trig_type_e;
endpackage

/* File: gpio_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  // pins in, filtered level out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, lvl_r, lvl_nxt;

  // level only moves once stages two and three agree
  always_comb begin
    lvl_nxt = lvl_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        lvl_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      lvl_r <= '0;
    end else if (ce) begin
      s1_r  <= async_in;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;
endmodule
`default_nettype wire

/* File: gpio_evt.sv */
`timescale 1ns/10ps
`default_nettype none
module gpio_evt #(
  parameter int PINS = 8
) (
  // current and previous filtered level
  input  wire logic [PINS-1:0]   lvl,
  input  wire logic [PINS-1:0]   lvl_prev,
  // three bits of trigger type per pin
  input  wire logic [3*PINS-1:0] trig_type,
  // detections
  output logic      [PINS-1:0]   edge_hit,
  output logic      [PINS-1:0]   level_hit,
  output logic      [PINS-1:0]   is_level
);
  gpio_pkg::trig_type_e t;

  always_comb begin
    t = gpio_pkg::trig_off;
    edge_hit  = '0;
    level_hit = '0;
    is_level  = '0;
    for (int i = 0; i < PINS; i++) begin
      t = gpio_pkg::trig_type_e'(trig_type[3*i +: 3]);
      case (t)
        gpio_pkg::trig_low_level: begin
          is_level[i]  = 1'b1;
          level_hit[i] = ~lvl[i];
        end
        gpio_pkg::trig_high_level: begin
          is_level[i]  = 1'b1;
          level_hit[i] = lvl[i];
        end
        gpio_pkg::trig_falling:    edge_hit[i] = lvl_prev[i] & ~lvl[i];
        gpio_pkg::trig_rising:     edge_hit[i] = ~lvl_prev[i] & lvl[i];
        gpio_pkg::trig_both_edges: edge_hit[i] = lvl_prev[i] ^ lvl[i];
        default:                   edge_hit[i] = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: gpio_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"
module gpio_port #(
  parameter int PINS = 8
) (
  // clock, reset, enable
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            ce,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // pads
  input  wire logic [PINS-1:0] pin_in,
  output logic      [PINS-1:0] pin_out,
  output logic      [PINS-1:0] pin_oe,
  output logic      [PINS-1:0] pull_up_en,
  output logic      [PINS-1:0] pull_down_en,
  // peripheral function side
  input  wire logic [PINS-1:0] periph_out,
  input  wire logic [PINS-1:0] periph_oe,
  output logic      [PINS-1:0] periph_in,
  output logic      [PINS-1:0] periph_sel,
  // triggers and interrupt
  output logic                 adc_trig,
  output logic                 dma_req,
  output logic                 irq
);
  localparam int SB = PINS + 1;

  // two-bit direction field of pin i
  function automatic gpio_pkg::dir_mode_e dir_of(input logic [2*PINS-1:0] d, input int i);
    dir_of = gpio_pkg::dir_mode_e'(d[2*i +: 2]);
  endfunction

  // ========================================================
  // state
  logic [PINS-1:0]   out_r, oden_r, pup_r, pdn_r, adcen_r, dmaen_r;
  logic [PINS-1:0]   out_nxt, oden_nxt, pup_nxt, pdn_nxt, adcen_nxt, dmaen_nxt;
  logic [2*PINS-1:0] dir_r, dir_nxt;
  logic [3*PINS-1:0] type_r, type_nxt;
  logic [SB-1:0]     ien_r, ien_nxt, st_r, st_nxt;
  logic [PINS-1:0]   prev_r, pin_out_nxt, pin_oe_nxt, sel_nxt;
  logic [31:0]       prdata_nxt;
  logic              pready_nxt, pslverr_nxt, adc_nxt, dma_nxt, irq_nxt;
  logic [PINS-1:0]   lvl, edge_hit, level_hit, is_level, hit;
  logic [PINS-1:0]   dmask, is_out, is_per;
  logic [SB-1:0]     clr;
  logic              wr, rd, is_data, mapped;

  // ========================================================
  // pin input filtering and event detection
  gpio_sync #(.WIDTH(PINS)) u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .async_in  (pin_in),
    .level_out (lvl)
  );

  gpio_evt #(.PINS(PINS)) u_evt (
    .lvl       (lvl),
    .lvl_prev  (prev_r),
    .trig_type (type_r),
    .edge_hit  (edge_hit),
    .level_hit (level_hit),
    .is_level  (is_level)
  );

  // events are detected for every configured pin, whatever the trigger enables
  assign hit = edge_hit | level_hit;

  // ========================================================
  // apb decode; access completes on the first access-phase edge
  assign wr      = psel & penable & pready & pwrite;
  assign rd      = psel & penable & pready & ~pwrite;
  assign is_data = paddr <= `GPIO_DATA_LAST;
  assign dmask   = paddr[`GPIO_MASK_LSB +: PINS];
  assign mapped  = is_data | (paddr >= `GPIO_DIR_OFS && paddr <= `GPIO_DMAEN_OFS && paddr[1:0] == 2'b00);

  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      is_out[i] = dir_of(dir_r, i) == gpio_pkg::dir_sw_output;
      is_per[i] = dir_of(dir_r, i) == gpio_pkg::dir_peripheral_controlled;
    end
  end

  // ========================================================
  // register file next state
  always_comb begin
    out_nxt   = out_r;
    dir_nxt   = dir_r;
    oden_nxt  = oden_r;
    pup_nxt   = pup_r;
    pdn_nxt   = pdn_r;
    type_nxt  = type_r;
    ien_nxt   = ien_r;
    adcen_nxt = adcen_r;
    dmaen_nxt = dmaen_r;
    clr       = '0;
    if (wr) begin
      if (is_data) begin
        out_nxt = (out_r & ~dmask) | (pwdata[PINS-1:0] & dmask);
      end
      case (paddr)
        `GPIO_DIR_OFS:   dir_nxt   = pwdata[2*PINS-1:0];
        `GPIO_ODEN_OFS:  oden_nxt  = pwdata[PINS-1:0];
        `GPIO_PUP_OFS:   pup_nxt   = pwdata[PINS-1:0];
        `GPIO_PDN_OFS:   pdn_nxt   = pwdata[PINS-1:0];
        `GPIO_TYPE_OFS:  type_nxt  = pwdata[3*PINS-1:0];
        `GPIO_IEN_OFS:   ien_nxt   = pwdata[SB-1:0];
        `GPIO_ICLR_OFS:  clr       = pwdata[SB-1:0];
        `GPIO_ADCEN_OFS: adcen_nxt = pwdata[PINS-1:0];
        `GPIO_DMAEN_OFS: dmaen_nxt = pwdata[PINS-1:0];
        default:         clr       = '0;
      endcase
    end
    // a raw read clears only the bits it returned, still held in prdata
    if (rd && paddr == `GPIO_RAW_OFS) begin
      clr = prdata[SB-1:0];
    end
  end

  // ========================================================
  // status: edge bits sticky with set over clear, level bits follow pin
  always_comb begin
    // trigger terms first: the dma status bit is built from dma_nxt
    adc_nxt = |(hit & adcen_r);
    dma_nxt = |(hit & dmaen_r);
    st_nxt  = (st_r & ~clr) | {dma_nxt, edge_hit};
    for (int i = 0; i < PINS; i++) begin
      if (is_level[i]) begin
        st_nxt[i] = level_hit[i];
      end
    end
    irq_nxt = |(st_nxt & ien_nxt);
  end

  // ========================================================
  // pad drive; follows the direction being written so drive and select switch together
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      sel_nxt[i] = dir_of(dir_nxt, i) == gpio_pkg::dir_peripheral_controlled;
      if (sel_nxt[i]) begin
        pin_out_nxt[i] = periph_out[i];
        pin_oe_nxt[i]  = periph_oe[i];
      end else if (dir_of(dir_nxt, i) == gpio_pkg::dir_sw_output) begin
        pin_out_nxt[i] = oden_nxt[i] ? 1'b0 : out_nxt[i];
        pin_oe_nxt[i]  = oden_nxt[i] ? ~out_nxt[i] : 1'b1;
      end else begin
        pin_out_nxt[i] = 1'b0;
        pin_oe_nxt[i]  = 1'b0;
      end
    end
  end

  // ========================================================
  // apb answer
  always_comb begin
    pready_nxt  = psel & ~penable;
    pslverr_nxt = psel & ~penable & ~mapped;
    prdata_nxt  = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      if (is_data) begin
        prdata_nxt[PINS-1:0] = dmask & ((is_out & out_r) | (~is_out & lvl));
      end else begin
        case (paddr)
          `GPIO_DIR_OFS:   prdata_nxt[2*PINS-1:0] = dir_r;
          `GPIO_ODEN_OFS:  prdata_nxt[PINS-1:0]   = oden_r;
          `GPIO_PUP_OFS:   prdata_nxt[PINS-1:0]   = pup_r;
          `GPIO_PDN_OFS:   prdata_nxt[PINS-1:0]   = pdn_r;
          `GPIO_TYPE_OFS:  prdata_nxt[3*PINS-1:0] = type_r;
          `GPIO_IEN_OFS:   prdata_nxt[SB-1:0]     = ien_r;
          `GPIO_RAW_OFS:   prdata_nxt[SB-1:0]     = st_r;
          `GPIO_MSK_OFS:   prdata_nxt[SB-1:0]     = st_r & ien_r;
          `GPIO_ADCEN_OFS: prdata_nxt[PINS-1:0]   = adcen_r;
          `GPIO_DMAEN_OFS: prdata_nxt[PINS-1:0]   = dmaen_r;
          default:         prdata_nxt             = 32'h0000_0000;
        endcase
      end
    end
  end

  // ========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r        <= `GPIO_BITS_RST;
      dir_r        <= `GPIO_DIR_RST;
      oden_r       <= `GPIO_BITS_RST;
      pup_r        <= `GPIO_BITS_RST;
      pdn_r        <= `GPIO_BITS_RST;
      type_r       <= `GPIO_TYPE_RST;
      ien_r        <= `GPIO_IEN_RST;
      st_r         <= `GPIO_IEN_RST;
      adcen_r      <= `GPIO_BITS_RST;
      dmaen_r      <= `GPIO_BITS_RST;
      prev_r       <= `GPIO_BITS_RST;
      pin_out      <= `GPIO_BITS_RST;
      pin_oe       <= `GPIO_BITS_RST;
      pull_up_en   <= `GPIO_BITS_RST;
      pull_down_en <= `GPIO_BITS_RST;
      periph_in    <= `GPIO_BITS_RST;
      periph_sel   <= `GPIO_BITS_RST;
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      adc_trig     <= 1'b0;
      dma_req      <= 1'b0;
      irq          <= 1'b0;
    end else if (ce) begin
      out_r        <= out_nxt;
      dir_r        <= dir_nxt;
      oden_r       <= oden_nxt;
      pup_r        <= pup_nxt;
      pdn_r        <= pdn_nxt;
      type_r       <= type_nxt;
      ien_r        <= ien_nxt;
      st_r         <= st_nxt;
      adcen_r      <= adcen_nxt;
      dmaen_r      <= dmaen_nxt;
      prev_r       <= lvl;
      pin_out      <= pin_out_nxt;
      pin_oe       <= pin_oe_nxt;
      // pull-down gives way when both are requested
      pull_up_en   <= pup_nxt;
      pull_down_en <= pdn_nxt & ~pup_nxt;
      periph_in    <= lvl & is_per;
      periph_sel   <= sel_nxt;
      prdata       <= prdata_nxt;
      pready       <= pready_nxt;
      pslverr      <= pslverr_nxt;
      adc_trig     <= adc_nxt;
      dma_req      <= dma_nxt;
      irq          <= irq_nxt;
    end
  end

  // ========================================================
  // checks
  a_reset_inputs: assert property (@(posedge pclk) $rose(presetn) |-> pin_oe == '0)
    else $error("pin driver on after reset");
  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(st_r & ien_r)) else $error("irq not gated by enable");
  a_masked_read: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && !penable && !pwrite && is_data |=> (prdata[PINS-1:0] & ~$past(dmask)) == '0)
    else $error("unselected pin visible in data read");
  a_masked_write: assert property (@(posedge pclk) disable iff (!presetn)
    ce && wr && is_data |=> ((out_r ^ $past(out_r)) & ~$past(dmask)) == '0
      && (out_r & $past(dmask)) == ($past(pwdata[PINS-1:0]) & $past(dmask)))
    else $error("masked write wrong");
  a_adc_enable: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (adcen_r == '0) |=> !adc_trig) else $error("adc trigger with enable cleared");
  a_adc_event: assert property (@(posedge pclk) disable iff (!presetn)
    ce && |(edge_hit & adcen_r) |=> adc_trig && (st_r & $past(edge_hit)) == $past(edge_hit))
    else $error("adc pin lost its event");
  a_dma_status: assert property (@(posedge pclk) disable iff (!presetn)
    ce && |(hit & dmaen_r) |=> dma_req && st_r[`GPIO_DMA_BIT]) else $error("dma event missing");
  a_edge_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_r[0] && !is_level[0] && !clr[0] |=> st_r[0]) else $error("edge status dropped");
  a_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 $past(ce) && !$past(sel_nxt[0]) && $past(oden_nxt[0]) |-> !pin_out[0])
    else $error("open-drain pin drove high");
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    ce && psel && !penable |=> pready) else $error("apb answer late");

  // ========================================================
  // bus, pad and status checks
  a_error_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready) else $error("bus error outside access phase");
  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:3*PINS] == '0) else $error("unused read bits set");
  a_pull_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
    (pull_up_en & pull_down_en) == '0) else $error("both pulls on");
  a_input_released: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !sel_nxt[0] && dir_of(dir_nxt, 0) != gpio_pkg::dir_sw_output |=> !pin_oe[0])
    else $error("input pin driven");
  a_port_owned: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !is_per[0] |=> !periph_in[0]) else $error("port pin leaked to peripheral");
  a_dma_enable: assert property (@(posedge pclk) disable iff (!presetn)
    ce && (dmaen_r == '0) |=> !dma_req) else $error("dma request with enable cleared");
  a_irq_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (ien_r == '0) |-> !irq) else $error("irq with all sources disabled");
  a_level_follows: assert property (@(posedge pclk) disable iff (!presetn)
    ce && is_level[0] |=> st_r[0] == $past(level_hit[0])) else $error("level status stale");
  a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rd && paddr == `GPIO_RAW_OFS && prdata[0] && !is_level[0] && !edge_hit[0] |=> !st_r[0])
    else $error("raw read left status set");

  // ========================================================
  // covers
  c_masked_write: cover property (@(posedge pclk) disable iff (!presetn) wr && is_data && dmask != '1);
  c_level_event: cover property (@(posedge pclk) disable iff (!presetn) |(level_hit & ien_r[PINS-1:0]));
  c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_adc_and_irq: cover property (@(posedge pclk) disable iff (!presetn) adc_trig && irq);
  c_periph_pin: cover property (@(posedge pclk) disable iff (!presetn) periph_sel != '0);
endmodule
`default_nettype wire

/* File: pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// external pads of the port
module pin_model (
  // clock
  input  wire logic       pclk,
  // device pad side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pull_up_en,
  input  wire logic [7:0] pull_down_en,
  // board driver
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_in
);
  logic [7:0] last_r = 8'h00;

  // a floating pad shows the inverse of its last level, so a stale value never passes
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pull_up_en[i]) pin_in[i] = 1'b1;
      else if (pull_down_en[i]) pin_in[i] = 1'b0;
      else pin_in[i] = ~last_r[i];
    end
  end

  always @(posedge pclk) last_r <= pin_in;
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gpio_consts.svh"
module tb_top;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, adc_trig, dma_req, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d, ex, ien;
  logic [7:0]  pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, periph_out, periph_oe, periph_in;
  logic [7:0]  periph_sel, ext_val, ext_en, out_m, od_m, pu_m, pd_m, m, v, eo, eoe, lv, cm, ev, pi;
  logic [1:0]  dir_m [8];
  int          errors, tests_run, adc_n, dma_n;

  gpio_port #(.PINS(8)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
    .periph_sel(periph_sel), .adc_trig(adc_trig), .dma_req(dma_req), .irq(irq));

  // pads are set up by the board before any traffic
  pin_model pad_u (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // ==========================================================
  // reporting and bus tasks
  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken as sampled at the rising edge that ends the transfer
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 40) errors++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    out_m = 8'h00;
    @(negedge pclk);
    chk("pin_oe", 32'h0, 32'(pin_oe));
    chk("pulls", 32'h0, 32'({pull_up_en, pull_down_en}));
    chk("periph_sel", 32'h0, 32'(periph_sel));
    chk("irq", 32'h0, 32'(irq));
    rdc("dir", `GPIO_DIR_OFS, 32'h0);
    rdc("oden", `GPIO_ODEN_OFS, 32'h0);
    rdc("pullup", `GPIO_PUP_OFS, 32'h0);
  endtask

  // one pad step on pin 0, then irq, trigger counts and both status views
  task automatic step(input logic [7:0] pv, input logic [31:0] sx, input int na, input int nd,
                      input logic clr);
    adc_n = 0;
    dma_n = 0;
    @(posedge pclk);
    ext_val <= pv;
    repeat (10) @(posedge pclk);
    @(negedge pclk);
    chk("irq", 32'(|(sx & ien)), 32'(irq));
    chk("adc_trig", na, adc_n);
    chk("dma_req", nd, dma_n);
    rdc("masked", `GPIO_MSK_OFS, sx & ien);
    if (clr) wr(`GPIO_ICLR_OFS, 32'h1FF);
    rdc("raw", `GPIO_RAW_OFS, clr ? 32'h0 : sx);
  endtask

  always @(negedge pclk) begin
    if (adc_trig === 1'b1) adc_n++;
    if (dma_req === 1'b1) dma_n++;
  end

  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // about thirty-five times the expected run
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    periph_out = 8'h00;
    periph_oe = 8'h00;
    ext_val = 8'h00;
    ext_en = 8'hFF;
    void'($urandom(32'hEFDB));
    do_reset();
    for (int k = 0; k < 8; k++) begin
      d = 32'h0;
      for (int i = 0; i < 8; i++) begin
        dir_m[i] = 2'($urandom % 3);
        d[2*i +: 2] = dir_m[i];
      end
      od_m = 8'($urandom);
      pu_m = 8'($urandom);
      pd_m = 8'($urandom);
      m = 8'($urandom);
      v = 8'($urandom);
      @(posedge pclk);
      periph_out <= 8'($urandom);
      periph_oe  <= 8'($urandom);
      ext_val    <= 8'($urandom);
      ext_en     <= ~(pu_m | pd_m);
      wr(`GPIO_DIR_OFS, d);
      wr(`GPIO_ODEN_OFS, 32'(od_m));
      wr(`GPIO_PUP_OFS, 32'(pu_m));
      wr(`GPIO_PDN_OFS, 32'(pd_m));
      wr({2'b00, m, 2'b00}, 32'(v));
      out_m = (out_m & ~m) | (v & m);
      repeat (6) @(posedge pclk);
      @(negedge pclk);
      for (int i = 0; i < 8; i++) begin
        cm[i]  = dir_m[i] != gpio_pkg::dir_sw_input;
        pi[i]  = dir_m[i] == gpio_pkg::dir_peripheral_controlled;
        eoe[i] = pi[i] ? periph_oe[i] : cm[i] & (od_m[i] ? ~out_m[i] : 1'b1);
        eo[i]  = pi[i] ? periph_out[i] : ~od_m[i] & out_m[i];
        lv[i]  = eoe[i] ? eo[i] : ext_en[i] ? ext_val[i] : pu_m[i];
      end
      chk("pin_oe", 32'(eoe), 32'(pin_oe));
      chk("pin_out", 32'(eo & cm), 32'(pin_out & cm));
      chk("pull_up_en", 32'(pu_m), 32'(pull_up_en));
      chk("pull_down_en", 32'(pd_m & ~pu_m), 32'(pull_down_en));
      chk("periph_sel", 32'(pi), 32'(periph_sel));
      chk("periph_in", 32'(pi & lv), 32'(periph_in));
      rdc("dir", `GPIO_DIR_OFS, d);
      m = 8'($urandom);
      for (int i = 0; i < 8; i++) ev[i] = m[i] & (dir_m[i] == gpio_pkg::dir_sw_output ? out_m[i] : lv[i]);
      rdc("data", {2'b00, m, 2'b00}, 32'(ev));
    end
    apb(1'b0, 12'h42C, 32'h0);
    chk("pslverr", 32'h1, 32'(err));
    chk("unmapped", 32'h0, rd);
    do_reset();
    @(posedge pclk);
    ext_en  <= 8'hFF;
    ext_val <= 8'h00;
    for (int t = 1; t < 6; t++) begin
      ien = (t == 3) ? 32'h0 : 32'h101;
      wr(`GPIO_TYPE_OFS, 32'(t));
      wr(`GPIO_IEN_OFS, ien);
      wr(`GPIO_ADCEN_OFS, 32'(t == 4));
      wr(`GPIO_DMAEN_OFS, 32'(t == 5));
      repeat (6) @(posedge pclk);
      apb(1'b0, `GPIO_RAW_OFS, 32'h0);
      ex = 32'(t == gpio_pkg::trig_high_level || t == gpio_pkg::trig_rising || t == gpio_pkg::trig_both_edges);
      step(8'h01, ex | (t == 5 ? 32'h100 : 32'h0), int'(t == 4), int'(t == 5), t == 4);
      ex = 32'(t == gpio_pkg::trig_low_level || t == gpio_pkg::trig_falling || t == gpio_pkg::trig_both_edges);
      step(8'h00, ex | (t == 5 ? 32'h100 : 32'h0), 0, int'(t == 5), 1'b0);
    end
    // clock enable low: the pin step stays unseen until it returns
    @(posedge pclk);
    ce      <= 1'b0;
    ext_val <= 8'h01;
    dma_n = 0;
    repeat (10) @(posedge pclk);
    @(negedge pclk);
    chk("irq_frozen", 32'h0, 32'(irq));
    chk("dma_frozen", 32'h0, 32'(dma_n));
    @(posedge pclk);
    ce <= 1'b1;
    step(8'h01, 32'h101, 0, 1, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
